// >>> rtl/rmac_map.svh
// Constants for the reorder memory address control
`ifndef RMAC_MAP_SVH
`define RMAC_MAP_SVH
`define RMAC_DATA_W 16
`define RMAC_ADDR_W 9
`define RMAC_CNT_W 11
`define RMAC_IDX_W 5
`define RMAC_NUM_MEM 8
`define RMAC_CASE_MAX 3'h4
`define RMAC_CLK_NS 25
`define RMAC_RD_PER_NS 400
`define RMAC_RD_SPAN_NS 500
`define RMAC_RD_PER_CYC (`RMAC_RD_PER_NS / `RMAC_CLK_NS)
`define RMAC_RD_LAG_CYC \
   ((`RMAC_RD_SPAN_NS - `RMAC_RD_PER_NS) / `RMAC_CLK_NS)
`define RMAC_AUG_SHIFT 5
`define RMAC_AUG_STEP_LOG 3
`define RMAC_QUOT_SHIFT 3
`endif

// >>> rtl/rmac_pkg.sv
// Types shared by the reorder memory address control
`include "rmac_map.svh"
package rmac_pkg;
   typedef struct packed {
      logic [`RMAC_DATA_W-1:0] sum;
      logic [`RMAC_DATA_W-1:0] dif;
   } rmac_samp_t;

   typedef struct packed {
      logic [`RMAC_NUM_MEM-1:0] cs;
      logic [`RMAC_NUM_MEM-1:0] wr;
      logic [3:0] load;
   } rmac_ctl_t;

   typedef logic [`RMAC_NUM_MEM-1:0][`RMAC_ADDR_W-1:0] rmac_wadr_t;

   typedef struct packed {
      logic [2:0] case1;
      logic [2:0] case2;
      logic aug1;
      logic aug2;
      logic [`RMAC_CNT_W-1:0] t;
      logic run;
      rmac_samp_t [1:0] fifo;
      logic [1:0] cnt;
      logic head;
      rmac_samp_t [1:0] hold;
      rmac_wadr_t wa;
      logic [`RMAC_ADDR_W-1:0] ra;
      logic [`RMAC_ADDR_W-1:0] rb;
      logic [4:0] tmr;
      logic [2:0] lag;
      logic [`RMAC_IDX_W-1:0] bidx;
      rmac_ctl_t ctl;
   } rmac_state_t;
endpackage

// >>> rtl/rmac_ctrl.sv
// Reorder memory address and strobe controller
// Summary of operation
// - Eight memories, each at half clock rate
// - Channels load alternate holders, held two steps
// - Each holder feeds two alternating memories
// - Read precedes write; sequential read addresses
// - Memories start reading word zero, 400 ns
// - Interim read address copy for B memories
// - Group one sum, group two difference
// - Per-memory size follows case table
// - Strobes decoded from the control counter
// - Shared read address spans twenty clocks
// - Own write address, held two steps
// - Base table plus aperture multiples of K
// - Address is base(t mod l) plus offset
// - Sum and difference addresses reduced modulo
// - Eleven bit time counter from aperture start
// - Quotient by dropping three bits, shifting
// - Optional augmented base table, steps eight
// - Difference address drops sum MSB
`timescale 1ns/1ps
`include "rmac_map.svh"
module rmac_ctrl (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Static configuration
   input wire logic [2:0] case_sel_i,
   input wire logic aug_mode_i,
   // Sample stream from the first transform
   input wire logic in_valid_i,
   input wire rmac_pkg::rmac_samp_t in_data_i,
   output logic in_ready_o,
   // Memory step permission
   input wire logic mem_ready_i,
   // External base address table
   output logic [`RMAC_IDX_W-1:0] base_idx_o,
   input wire logic [`RMAC_ADDR_W-1:0] base_addr_i,
   // Memory side
   output rmac_pkg::rmac_samp_t [1:0] hold_o,
   output rmac_pkg::rmac_wadr_t wr_addr_o,
   output logic [`RMAC_ADDR_W-1:0] rd_addr_a_o,
   output logic [`RMAC_ADDR_W-1:0] rd_addr_b_o,
   output rmac_pkg::rmac_ctl_t ctl_o,
   output logic [`RMAC_CNT_W-1:0] time_o
);

   localparam logic [4:0] RD_PER = 5'(`RMAC_RD_PER_CYC);
   localparam logic [2:0] RD_LAG = 3'(`RMAC_RD_LAG_CYC);

   rmac_pkg::rmac_state_t st_q;
   rmac_pkg::rmac_state_t st_d;

   // Shift that turns t/8 into t/l for the selected case
   function automatic logic [1:0] quot_shift(input logic [2:0] c);
      logic [1:0] m;
      m = 2'h0;
      case (c)
         3'h0, 3'h1: m = 2'h0;
         3'h2, 3'h3: m = 2'h1;
         default: m = 2'h2;
      endcase
      return m;
   endfunction

   // Sum memory length mask, 32 words for case one up to 512
   function automatic logic [`RMAC_ADDR_W-1:0] sum_mask(
      input logic [2:0] c);
      logic [`RMAC_ADDR_W-1:0] k;
      k = 9'h01f;
      case (c)
         3'h0: k = 9'h01f;
         3'h1: k = 9'h03f;
         3'h2: k = 9'h07f;
         3'h3: k = 9'h0ff;
         default: k = 9'h1ff;
      endcase
      return k;
   endfunction

   logic [2:0] cq;
   logic adv;
   logic push;
   logic tail;
   logic [1:0] m;
   logic [`RMAC_CNT_W-1:0] quot;
   logic [`RMAC_CNT_W-1:0] offs;
   logic [`RMAC_CNT_W-1:0] full;
   logic [`RMAC_ADDR_W-1:0] amax;
   logic [`RMAC_ADDR_W-1:0] asum;
   logic [`RMAC_ADDR_W-1:0] adif;
   logic [`RMAC_CNT_W-1:0] pv;
   logic [`RMAC_CNT_W-1:0] tn;

   // Clamp an out-of-range case to the largest configuration
   assign cq = (st_q.case2 > `RMAC_CASE_MAX) ? `RMAC_CASE_MAX
                                              : st_q.case2;
   assign m = quot_shift(cq);
   assign amax = sum_mask(cq);
   assign adv = (st_q.cnt != 2'h0) && mem_ready_i;
   assign push = in_valid_i && (st_q.cnt != 2'h2);
   assign tail = st_q.head ^ st_q.cnt[0];
   assign pv = st_q.t - 11'h001;

   // Write address arithmetic for the current time index
   always_comb begin
      quot = 11'h000;
      if (st_q.aug2) begin
         offs = {st_q.t[`RMAC_CNT_W-1:`RMAC_AUG_SHIFT],
                 5'h00} >> (`RMAC_AUG_SHIFT - `RMAC_AUG_STEP_LOG);
      end else begin
         quot = {3'h0, st_q.t[`RMAC_CNT_W-1:`RMAC_QUOT_SHIFT]} >> m;
         offs = quot << (m + 2'h1);
      end
      full = {2'h0, base_addr_i} + offs;
      asum = full[`RMAC_ADDR_W-1:0] & amax;
      adif = asum & (amax >> 1);
   end

   // Next state: buffer, counters, addresses and strobes
   always_comb begin
      st_d = st_q;
      st_d.case1 = case_sel_i;
      st_d.case2 = st_q.case1;
      st_d.aug1 = aug_mode_i;
      st_d.aug2 = st_q.aug1;
      st_d.ctl = '0;
      // Two-entry buffer keeps words while memories stall
      if (push) begin
         st_d.fifo[tail] = in_data_i;
      end
      if (adv) begin
         st_d.head = ~st_q.head;
      end
      st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, adv};
      if (adv) begin
         st_d.run = 1'b1;
         st_d.t = st_q.t + 11'h001;
         // Holders alternate per step so each holds two steps
         st_d.hold[st_q.t[0]] = st_q.fifo[st_q.head];
         st_d.ctl.load[{1'b0, st_q.t[0]}] = 1'b1;
         st_d.ctl.load[{1'b1, st_q.t[0]}] = 1'b1;
         // Index is {group, holder, unit}; group 0 is the sum
         st_d.wa[{1'b0, st_q.t[0], st_q.t[1]}] = asum;
         st_d.wa[{1'b1, st_q.t[0], st_q.t[1]}] = adif;
         // Memory read this step, written the next one
         st_d.ctl.cs[{1'b0, st_q.t[0], st_q.t[1]}] = 1'b1;
         st_d.ctl.cs[{1'b1, st_q.t[0], st_q.t[1]}] = 1'b1;
         if (st_q.run) begin
            st_d.ctl.cs[{1'b0, pv[0], pv[1]}] = 1'b1;
            st_d.ctl.cs[{1'b1, pv[0], pv[1]}] = 1'b1;
            st_d.ctl.wr[{1'b0, pv[0], pv[1]}] = 1'b1;
            st_d.ctl.wr[{1'b1, pv[0], pv[1]}] = 1'b1;
         end
      end
      // Base table index for the next time index
      tn = st_d.t;
      if (st_q.aug2) begin
         st_d.bidx = tn[`RMAC_IDX_W-1:0];
      end else begin
         st_d.bidx = tn[`RMAC_IDX_W-1:0]
                     & 5'((6'h08 << quot_shift(cq)) - 6'h01);
      end
      // Sequential read address; B copy trails so a value spans
      // the whole first read cycle of all four memories
      if (st_q.run) begin
         if (st_q.tmr == RD_PER - 5'h01) begin
            st_d.tmr = 5'h00;
            st_d.ra = (st_q.ra + 9'h001) & amax;
            st_d.lag = RD_LAG;
         end else begin
            st_d.tmr = st_q.tmr + 5'h01;
         end
      end
      if (st_q.lag == 3'h1) begin
         st_d.rb = st_q.ra;
      end
      if (st_q.lag != 3'h0) begin
         st_d.lag = (st_q.tmr == RD_PER - 5'h01) ? RD_LAG
                                                  : st_q.lag - 3'h1;
      end
      // Reset restarts the first aperture; the option synchronisers
      // keep loading so a step right after release sees the real case
      if (rst_i) begin
         st_d = '0;
         st_d.case1 = case_sel_i;
         st_d.case2 = st_q.case1;
         st_d.aug1 = aug_mode_i;
         st_d.aug2 = st_q.aug1;
      end
   end

   // State register
   always_ff @(posedge clock_i) begin
      st_q <= st_d;
   end

   // Outputs
   assign in_ready_o = (st_q.cnt != 2'h2);
   assign base_idx_o = st_q.bidx;
   assign hold_o = st_q.hold;
   assign wr_addr_o = st_q.wa;
   assign rd_addr_a_o = st_q.ra;
   assign rd_addr_b_o = st_q.rb;
   assign ctl_o = st_q.ctl;
   assign time_o = st_q.t;

   // A write always follows the read of the same memory
   rd_then_wr_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (|st_q.ctl.wr) && $past(|st_q.ctl.cs)
      |-> st_q.ctl.wr == $past(st_q.ctl.cs & ~st_q.ctl.wr))
      else $error("write not preceded by read of same memory");

   // At most one memory per group writes each step
   one_writer_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $onehot0(st_q.ctl.wr[3:0]) && $onehot0(st_q.ctl.wr[7:4]))
      else $error("two memories of one group write together");

   // A holding register stays put for the following step
   hold_stable_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $changed(st_q.hold[0]) |=> $stable(st_q.hold[0]))
      else $error("holding register reloaded too early");

   // B read address copies A after the fixed lag
   rd_copy_lag_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $changed(st_q.ra) |-> ##4 (st_q.rb == $past(st_q.ra, 4)))
      else $error("B read address copy late or wrong");

   // Read address steps only at the end of its period
   rd_period_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $changed(st_q.ra) |-> $past(st_q.tmr) == RD_PER - 5'h01)
      else $error("read address stepped off period");

   // A fresh write address stands for the next step too
   wa_held_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $changed(st_q.wa[0]) |=> $stable(st_q.wa[0]))
      else $error("write address not held two cycles");

   // Difference address equals sum address less its top bit
   dif_from_sum_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $changed(st_q.wa[4]) |-> st_q.wa[4] == (st_q.wa[0] & (amax >> 1)))
      else $error("difference address mismatch");

   // Sum write address never exceeds memory length
   sum_modulo_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $changed(st_q.wa[0]) |-> (st_q.wa[0] & ~amax) == 9'h000)
      else $error("sum write address out of range");

   // Time counter advances once per accepted step
   time_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
      adv |=> st_q.t == $past(st_q.t) + 11'h001)
      else $error("time counter failed to advance");

   // Both groups load the same holder in one step
   load_pair_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      |st_q.ctl.load |-> st_q.ctl.load inside {4'h5, 4'ha})
      else $error("holding register loads not paired");

   // Strobes only follow an accepted step
   ctl_idle_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !$past(adv) |-> st_q.ctl == '0)
      else $error("strobe without a memory step");

   // Sum and difference groups run in lockstep
   grp_mirror_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      st_q.ctl.cs[3:0] == st_q.ctl.cs[7:4]
      && st_q.ctl.wr[3:0] == st_q.ctl.wr[7:4])
      else $error("memory groups out of step");

   // Time index holds while no step is taken
   time_hold_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      !adv |=> $stable(st_q.t))
      else $error("time counter moved without a step");

   // Read addresses stay inside the memory length
   rd_range_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      ((st_q.ra | st_q.rb) & ~amax) == 9'h000)
      else $error("read address beyond memory length");

   // Read period timer never passes its period
   tmr_range_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      st_q.tmr < RD_PER)
      else $error("read period timer out of range");

   // The first step after reset only reads
   first_read_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $past(adv) && !$past(st_q.run) |-> st_q.ctl.wr == 8'h00)
      else $error("write on the first step");

   // A write strobe always comes with its chip select
   wr_has_cs_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      (st_q.ctl.wr & ~st_q.ctl.cs) == 8'h00)
      else $error("write without chip select");

   // Reset leaves time and read address at the start
   rst_clear_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      $past(rst_i) |-> st_q.t == 11'h000 && st_q.ra == 9'h000)
      else $error("sequencing not restarted by reset");

   // B copy changes only when the lag runs out
   rb_stable_a: assert property (
      @(posedge clock_i) disable iff (rst_i)
      st_q.lag != 3'h1 |=> $stable(st_q.rb))
      else $error("B read address changed off its lag");

endmodule

// >>> dv/rmac_mem_model.sv
// Bench model of the base table and memory side of the controller
`timescale 1ns/1ps
`include "rmac_map.svh"
module rmac_mem_model (
   // Table lookup
   input wire logic [`RMAC_IDX_W-1:0] idx_i,
   output logic [`RMAC_ADDR_W-1:0] base_o,
   // Memory pacing
   input wire logic stall_i,
   output logic ready_o
);
   // Answers in the same cycle, like an asynchronous table
   assign base_o = {idx_i, 4'h3};
   // Memories refuse steps while the bench asks for a slow answer
   assign ready_o = !stall_i;
endmodule

// >>> dv/rmac_ctrl_bench.sv
// Self-checking bench for the reorder memory address control
`timescale 1ns/1ps
`include "rmac_map.svh"
module rmac_ctrl_bench;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] case_sel = 3'h0;
   logic aug = 1'b0;
   logic in_valid = 1'b0;
   rmac_pkg::rmac_samp_t in_data = '0;
   logic stall = 1'b0;
   logic in_ready, mem_ready;
   logic [`RMAC_IDX_W-1:0] bidx;
   logic [`RMAC_ADDR_W-1:0] baddr, ra, rb;
   rmac_pkg::rmac_samp_t [1:0] hold;
   rmac_pkg::rmac_wadr_t wa;
   rmac_pkg::rmac_ctl_t ctl;
   logic [`RMAC_CNT_W-1:0] tm;
   int err_total = 0;
   int checked = 0;

   // Clock
   always #12.5 clock_i = ~clock_i;

   rmac_ctrl dut (.clock_i(clock_i), .rst_i(rst_i), .case_sel_i(case_sel),
      .aug_mode_i(aug), .in_valid_i(in_valid), .in_data_i(in_data),
      .in_ready_o(in_ready), .mem_ready_i(mem_ready), .base_idx_o(bidx),
      .base_addr_i(baddr), .hold_o(hold), .wr_addr_o(wa),
      .rd_addr_a_o(ra), .rd_addr_b_o(rb), .ctl_o(ctl), .time_o(tm));
   rmac_mem_model far (.idx_i(bidx), .base_o(baddr), .stall_i(stall),
      .ready_o(mem_ready));

   task automatic stop_test;
      $display("checked %0d, err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic cmp_v(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_b(string what, logic exp, logic got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // Sum carries the time index, difference its inverse
   function automatic rmac_pkg::rmac_samp_t samp(logic [10:0] t);
      return {5'h00, t, 5'h1f, ~t};
   endfunction

   task automatic do_reset(logic [2:0] c, logic a);
      @(posedge clock_i);
      case_sel <= c;
      aug <= a;
      rst_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      #1;
      cmp_v("time", 0, tm);
      cmp_v("ctl", 0, ctl);
      cmp_v("rd addr", 0, ra);
      cmp_b("in_ready", 1'b1, in_ready);
   endtask

   task automatic push(logic [10:0] t);
      @(posedge clock_i);
      in_data <= samp(t);
      in_valid <= 1'b1;
      #1;
      while (!in_ready) begin
         @(posedge clock_i);
         #1;
      end
      @(posedge clock_i);
      in_valid <= 1'b0;
   endtask

   // Waits for one memory step and judges everything it produced
   task automatic step_check(logic [10:0] t);
      int l, off, sum;
      logic [2:0] m;
      logic [2:0] k;
      logic [10:0] pt;
      logic [7:0] wexp;
      // Case codes above four behave as case five
      k = (case_sel > 3'h4) ? 3'h4 : case_sel;
      l = (aug || k > 3) ? 32 : 8 << (k >> 1);
      off = (t / l) * (l / 4);
      sum = ({t % l, 4'h3} + off) % (32 << k);
      m = {1'b0, t[0], t[1]};
      pt = t - 11'h001;
      // Memory read one step ago is written now; none at the start
      wexp = (t == 11'h000) ? 8'h00 : 8'h11 << {pt[0], pt[1]};
      for (int i = 0; i < 6; i++) begin
         @(posedge clock_i);
         #1;
         if (ctl.load != 4'h0) break;
      end
      cmp_v("time", t + 1, tm);
      cmp_v("hold", samp(t), hold[t[0]]);
      cmp_v("load", 4'h5 << t[0], ctl.load);
      cmp_b("cs", 1'b1, ctl.cs[m]);
      cmp_b("rd first", 1'b0, ctl.wr[m]);
      cmp_v("sum addr", sum, wa[m]);
      cmp_v("dif addr", sum % (16 << k), wa[m + 4]);
      cmp_v("wr all", wexp, ctl.wr);
      cmp_v("cs all", wexp | (8'h11 << m), ctl.cs);
   endtask

   // Read address steps every 16 clocks; B copy trails by 4
   task automatic rd_check;
      logic [8:0] old;
      logic [2:0] k;
      k = (case_sel > 3'h4) ? 3'h4 : case_sel;
      old = ra;
      for (int i = 0; i < 20 && ra == old; i++) begin
         @(posedge clock_i);
         #1;
      end
      old = ra;
      repeat (4) @(posedge clock_i);
      #1;
      cmp_v("rd b", old, rb);
      repeat (12) @(posedge clock_i);
      #1;
      cmp_v("rd a", (old + 1) % (32 << k), ra);
   endtask

   // Two words wait in the buffer while memories stall, none lost
   task automatic buf_check(logic [10:0] t);
      @(posedge clock_i);
      stall <= 1'b1;
      in_valid <= 1'b1;
      in_data <= samp(t);
      @(posedge clock_i);
      in_data <= samp(t + 1);
      @(posedge clock_i);
      in_valid <= 1'b0;
      #1;
      cmp_b("in_ready", 1'b0, in_ready);
      cmp_v("ctl", 0, ctl);
      @(posedge clock_i);
      stall <= 1'b0;
      step_check(t);
      step_check(t + 1);
      cmp_b("in_ready", 1'b1, in_ready);
   endtask

   task automatic run_case(logic [2:0] c, logic a);
      do_reset(c, a);
      for (int t = 0; t < 40; t++) begin
         push(11'(t));
         step_check(11'(t));
      end
      rd_check;
      buf_check(11'h028);
   endtask

   // Every case, the augmented table on the largest case, then an
   // out-of-range case code that must act as the largest case
   initial begin
      for (int c = 0; c < 7; c++) begin
         run_case(c == 5 ? 3'h4 : (c == 6 ? 3'h7 : 3'(c)), c == 5);
      end
      stop_test;
   end

   // Watchdog, far beyond the expected twelve hundred or so clocks
   initial begin
      #200000;
      err_total++;
      stop_test;
   end
endmodule
